//--- shared/tcmp_pkg.sv
// constants and types for the 8-bit compare-output timer
package tcmp_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNT   = 8'h04;
  localparam logic [7:0] OFF_COMPARE = 8'h08;
  localparam logic [7:0] OFF_FLAGS   = 8'h0C;
  localparam logic [7:0] OFF_PIN     = 8'h10;

  // control field positions
  localparam int CTL_WAVE_LO  = 0;
  localparam int CTL_OUT_LO   = 2;
  localparam int CTL_CLK_LO   = 4;
  localparam int CTL_FORCE    = 7;
  // flag bit positions
  localparam int FLG_OVF      = 0;
  localparam int FLG_CMP      = 1;
  // pin register bit positions
  localparam int PIN_DATA     = 0;
  localparam int PIN_DIR      = 1;
  localparam int PIN_STATE    = 2;

  // counter extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // prescaler width for divide by 1024
  localparam int PRE_W = 10;

  // waveform generation modes
  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'h0,
    WAVE_PHASE  = 2'h1,
    WAVE_CLEAR  = 2'h2,
    WAVE_FAST   = 2'h3
  } tcmp_wave_e;

  // compare output actions in non-PWM modes
  typedef enum logic [1:0] {
    OUT_NONE   = 2'h0,
    OUT_TOGGLE = 2'h1,
    OUT_CLEAR  = 2'h2,
    OUT_SET    = 2'h3
  } tcmp_out_e;

  // control register contents
  typedef struct packed {
    logic [2:0] clockSelect;
    tcmp_out_e  compareOutputMode;
    tcmp_wave_e waveformMode;
  } tcmp_ctrl_s;

endpackage : tcmp_pkg

//--- rtl/tcmp_timer8.sv
// 8-bit timer with compare output and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

module tcmp_timer8 #(
  parameter int ADDR_W = 8                     // byte address width
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // interrupt service acknowledges
  input  wire logic              overflowServiced,
  input  wire logic              compareServiced,
  // flags for the interrupt controller
  output var  logic              overflowFlag,
  output var  logic              compareFlag,
  // compare pin drive
  output var  logic              comparePinOut,
  output var  logic              comparePinOe
);

  // software-visible state, plus the prescaler that cannot be read
  tcmp_pkg::tcmp_ctrl_s ctrl;                  // mode and clock selection
  logic [7:0]           counterValue;          // running count
  logic [7:0]           compareValue;          // unbuffered compare
  logic                 compareOutputState;    // internal output latch
  logic                 portData;              // general port value
  logic                 compareDirBit;         // pin direction bit
  logic [tcmp_pkg::PRE_W-1:0] prescale;        // free prescaler

  // bus decode
  logic       wrFire;                          // write taken
  logic       rdFire;                          // read taken
  logic [7:0] wrAddr;                          // write byte address
  logic [7:0] rdAddr;                          // read byte address
  logic       wrLow;                           // low byte enabled
  logic [7:0] wrByte;                          // low write byte

  // timer events
  logic timerClockEnable;                      // one tick
  logic match;                                 // count equals compare
  logic nonPwm;                                // normal or clear mode
  logic forceNow;                              // force strobe written
  logic ctrlWrite;                             // control written
  logic countWrite;                            // counter written
  logic flagWrite;                             // flags written
  logic pinWrite;                              // pin register written
  logic next_state;                            // next compare state
  logic next_pin;                              // next pin drive level
  tcmp_pkg::tcmp_out_e actMode;                // output action in use

  // mask selecting the prescaler bits for a clock select code
  function automatic logic [tcmp_pkg::PRE_W-1:0] divMask(
    input logic [2:0] sel
  );
    case (sel)
      3'h2:    divMask = 10'h007;              // divide by 8
      3'h3:    divMask = 10'h01F;              // divide by 32
      3'h4:    divMask = 10'h03F;              // divide by 64
      3'h5:    divMask = 10'h07F;              // divide by 128
      3'h6:    divMask = 10'h0FF;              // divide by 256
      3'h7:    divMask = 10'h3FF;              // divide by 1024
      default: divMask = 10'h000;              // divide by 1
    endcase
  endfunction : divMask

  // true when the byte address names a mapped register
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == tcmp_pkg::OFF_CONTROL) ||
               (a == tcmp_pkg::OFF_COUNT)   ||
               (a == tcmp_pkg::OFF_COMPARE) ||
               (a == tcmp_pkg::OFF_FLAGS)   ||
               (a == tcmp_pkg::OFF_PIN);
  endfunction : isMapped

  // true for the two non-PWM waveform modes
  function automatic logic isNonPwm(input tcmp_pkg::tcmp_wave_e w);
    isNonPwm = (w == tcmp_pkg::WAVE_NORMAL) ||
               (w == tcmp_pkg::WAVE_CLEAR);
  endfunction : isNonPwm

  // bus handshakes and strobes
  assign wrFire = s_axi_awvalid && s_axi_awready &&
                  s_axi_wvalid && s_axi_wready;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  assign wrAddr = 8'(s_axi_awaddr);
  assign rdAddr = 8'(s_axi_araddr);
  assign wrLow  = s_axi_wstrb[0];
  assign wrByte = s_axi_wdata[7:0];
  assign ctrlWrite  = wrFire && wrLow && (wrAddr == tcmp_pkg::OFF_CONTROL);
  assign countWrite = wrFire && wrLow && (wrAddr == tcmp_pkg::OFF_COUNT);
  assign flagWrite  = wrFire && wrLow && (wrAddr == tcmp_pkg::OFF_FLAGS);
  assign pinWrite   = wrFire && wrLow && (wrAddr == tcmp_pkg::OFF_PIN);

  // tick generation; select zero stops the timer
  assign timerClockEnable = (ctrl.clockSelect != 3'h0) &&
    ((prescale & divMask(ctrl.clockSelect)) ==
      divMask(ctrl.clockSelect));

  // comparator and mode class
  assign match  = (counterValue == compareValue);
  assign nonPwm = isNonPwm(ctrl.waveformMode);
  // force judged against the modes carried in the same control write
  assign forceNow = ctrlWrite && wrByte[tcmp_pkg::CTL_FORCE] &&
    isNonPwm(tcmp_pkg::tcmp_wave_e'(wrByte[tcmp_pkg::CTL_WAVE_LO +: 2]));
  // a force applies the newly written action, a match the stored one
  assign actMode = forceNow ?
    tcmp_pkg::tcmp_out_e'(wrByte[tcmp_pkg::CTL_OUT_LO +: 2]) :
    ctrl.compareOutputMode;

  // write address and data accepted together, one at a time
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (!s_axi_awready && !s_axi_bvalid &&
                 s_axi_awvalid && s_axi_wvalid) begin
      s_axi_awready <= 1'b1;                   // accept both next edge
      s_axi_wready  <= 1'b1;
    end else begin
      s_axi_awready <= 1'b0;                   // one-cycle ready
      s_axi_wready  <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tcmp_pkg::RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= isMapped(wrAddr) ? tcmp_pkg::RESP_OKAY
                                       : tcmp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;                    // response taken
    end
  end

  // read address ready
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  // read data mux
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= tcmp_pkg::RESP_OKAY;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= isMapped(rdAddr) ? tcmp_pkg::RESP_OKAY
                                       : tcmp_pkg::RESP_SLVERR;
      case (rdAddr)
        tcmp_pkg::OFF_CONTROL: s_axi_rdata <= {25'h0, 7'(ctrl)};
        tcmp_pkg::OFF_COUNT:   s_axi_rdata <= {24'h0, counterValue};
        tcmp_pkg::OFF_COMPARE: s_axi_rdata <= {24'h0, compareValue};
        tcmp_pkg::OFF_FLAGS:
          s_axi_rdata <= {30'h0, compareFlag, overflowFlag};
        tcmp_pkg::OFF_PIN:
          s_axi_rdata <= {29'h0, compareOutputState, compareDirBit,
                          portData};
        default:               s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;                    // data taken
    end
  end

  // control register; new output mode used from next match on
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= '0;
    end else if (ctrlWrite) begin
      ctrl <= tcmp_pkg::tcmp_ctrl_s'(wrByte[6:0]);
    end
  end

  // unbuffered compare value
  always_ff @(posedge clk) begin
    if (rst) begin
      compareValue <= tcmp_pkg::CNT_BOTTOM;
    end else if (wrFire && wrLow && (wrAddr == tcmp_pkg::OFF_COMPARE)) begin
      compareValue <= wrByte;
    end
  end

  // free-running prescaler
  always_ff @(posedge clk) begin
    if (rst) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // counter: software write first, then mode-driven counting
  always_ff @(posedge clk) begin
    if (rst) begin
      counterValue <= tcmp_pkg::CNT_BOTTOM;
    end else if (countWrite) begin
      counterValue <= wrByte;
    end else if (timerClockEnable) begin
      // only the waveform mode and a compare match steer counting
      if (ctrl.waveformMode == tcmp_pkg::WAVE_CLEAR && match) begin
        counterValue <= tcmp_pkg::CNT_BOTTOM;
      end else begin
        counterValue <= counterValue + 8'h01;
      end
    end
  end

  // overflow flag: set on max to zero in the non-PWM modes only, set beats clear
  always_ff @(posedge clk) begin
    if (rst) begin
      overflowFlag <= 1'b0;
    end else if (timerClockEnable && nonPwm && !countWrite &&
                 counterValue == tcmp_pkg::CNT_MAX) begin
      overflowFlag <= 1'b1;
    end else if (overflowServiced ||
                 (flagWrite && wrByte[tcmp_pkg::FLG_OVF])) begin
      overflowFlag <= 1'b0;
    end
  end

  // compare flag: set on the tick after a match
  always_ff @(posedge clk) begin
    if (rst) begin
      compareFlag <= 1'b0;
    end else if (timerClockEnable && match) begin
      compareFlag <= 1'b1;
    end else if (compareServiced ||
                 (flagWrite && wrByte[tcmp_pkg::FLG_CMP])) begin
      compareFlag <= 1'b0;
    end
  end

  // next compare-output state for a match or a force strobe
  always_comb begin
    next_state = compareOutputState;
    if (forceNow || (timerClockEnable && match && nonPwm)) begin
      unique case (actMode)
        tcmp_pkg::OUT_NONE:   next_state = compareOutputState;
        tcmp_pkg::OUT_TOGGLE: next_state = !compareOutputState;
        tcmp_pkg::OUT_CLEAR:  next_state = 1'b0;
        tcmp_pkg::OUT_SET:    next_state = 1'b1;
      endcase
    end
  end

  // compare-output state; software preset wins for initialising
  always_ff @(posedge clk) begin
    if (rst) begin
      compareOutputState <= 1'b0;
    end else if (pinWrite) begin
      compareOutputState <= wrByte[tcmp_pkg::PIN_STATE];
    end else begin
      compareOutputState <= next_state;
    end
  end

  // general port value and direction bit
  always_ff @(posedge clk) begin
    if (rst) begin
      portData      <= 1'b0;
      compareDirBit <= 1'b0;
    end else if (pinWrite) begin
      portData      <= wrByte[tcmp_pkg::PIN_DATA];
      compareDirBit <= wrByte[tcmp_pkg::PIN_DIR];
    end
  end

  // pin source: override depends only on the output mode
  always_comb begin
    if (ctrl.compareOutputMode != tcmp_pkg::OUT_NONE) begin
      next_pin = compareOutputState;
    end else begin
      next_pin = portData;
    end
  end

  // registered pin drive; enable follows direction bit only
  always_ff @(posedge clk) begin
    if (rst) begin
      comparePinOut <= 1'b0;
      comparePinOe  <= 1'b0;
    end else begin
      comparePinOut <= next_pin;
      comparePinOe  <= compareDirBit;
    end
  end

endmodule : tcmp_timer8

`default_nettype wire

//--- dv/tcmp_timer8_properties.sv
// concurrent checks on the timer's bus and flag ports
`timescale 1ns/1ps
`default_nettype none
module tcmp_timer8_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        overflowServiced,
  input wire logic        compareServiced,
  input wire logic        overflowFlag,
  input wire logic        compareFlag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // flags drop only through service or a register write
  a_ovf_clear_cause: assert property ($fell(overflowFlag) |->
    $past(overflowServiced) || $past(s_axi_awready))
    else $error("overflow flag dropped with no cause");
  a_cmp_clear_cause: assert property ($fell(compareFlag) |->
    $past(compareServiced) || $past(s_axi_awready))
    else $error("compare flag dropped with no cause");
  // write channels taken together, answered next cycle
  a_aw_w_together: assert property (s_axi_awready |-> s_axi_wready)
    else $error("address and data not taken together");
  a_b_after_take: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  a_b_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  // read channel
  a_r_after_take: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  a_ar_one_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held");
  a_err_zero_data: assert property (s_axi_rvalid &&
    s_axi_rresp == tcmp_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
endmodule : tcmp_timer8_props
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the 8-bit compare-output timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ovfSvc, cmpSvc;
  logic        ovfFlag, cmpFlag, pinOut, pinOe;
  logic [7:0]  awaddr, araddr;     // byte addresses
  logic [31:0] wdata, rdata, rv;   // bus words, last read
  logic [1:0]  bresp, rresp, rsp;  // responses, last response
  int          errCount, nChecks, n;

  tcmp_timer8 tcmp_timer8_i (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .overflowServiced(ovfSvc),
    .compareServiced(cmpSvc), .overflowFlag(ovfFlag),
    .compareFlag(cmpFlag), .comparePinOut(pinOut), .comparePinOe(pinOe));

  always #50 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rsp = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rv = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask : rd

  // reset contents and an unmapped place
  task automatic t_reset();
    for (int a = 0; a <= 16; a += 4) begin
      rd(8'(a));
      chk("reset word", rv, 32'h0);
    end
    rd(8'h14);
    chk("unmapped read data", rv, 32'h0);
    chk("unmapped read resp", 32'(rsp), 32'h2);
    wr(8'h14, 32'hFF);
    chk("unmapped write", 32'(rsp), 32'h2);
  endtask : t_reset

  // write then look at the pin after it settles
  task automatic pin(input logic [7:0] a, input logic [7:0] d,
                     input logic oe, input logic lvl);
    wr(a, 32'(d));
    repeat (2) @(posedge clk);
    chk("pin enable", 32'(pinOe), 32'(oe));
    chk("pin level", 32'(pinOut), 32'(lvl));
  endtask : pin

  task automatic t_pin();
    pin(8'h10, 8'h06, 1'h1, 1'h0);
    pin(8'h00, 8'h88, 1'h1, 1'h0);
    rd(8'h10);
    chk("forced clear", rv, 32'h02);
    pin(8'h00, 8'h8C, 1'h1, 1'h1);
    rd(8'h00);
    chk("force reads zero", rv, 32'h0C);
    pin(8'h00, 8'h80, 1'h1, 1'h0);
    rd(8'h10);
    chk("mode zero keeps", rv, 32'h06);
    pin(8'h10, 8'h05, 1'h0, 1'h1);
    pin(8'h00, 8'h04, 1'h0, 1'h1);
    pin(8'h10, 8'h03, 1'h1, 1'h0);
    pin(8'h00, 8'h0F, 1'h1, 1'h0);
  endtask : t_pin

  // clear-on-match toggle period on the pin
  task automatic t_period(input logic [2:0] sel, input logic [7:0] cmp,
                          input int exp);
    logic p;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'(cmp));
    wr(8'h10, 32'h02);
    wr(8'h00, {24'h0, 1'h0, sel, 4'h6});
    for (int k = 0; k < 2; k++) begin
      p = pinOut;
      n = 0;
      while (pinOut === p && n < 3000) begin
        @(negedge clk);
        n++;
      end
    end
    chk("toggle interval", 32'(n), 32'(exp));
    wr(8'h00, 32'h0);
  endtask : t_period

  task automatic t_overflow();
    wr(8'h0C, 32'h03);
    wr(8'h04, 32'hFE);
    repeat (20) @(posedge clk);
    rd(8'h04);
    chk("stopped count", rv, 32'hFE);
    wr(8'h00, 32'h10);
    n = 0;
    while (ovfFlag !== 1'h1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    wr(8'h00, 32'h0);
    rd(8'h04);
    chk("wrapped low", 32'(rv > 32'h0 && rv < 32'h10), 32'h1);
    chk("overflow set", 32'(ovfFlag), 32'h1);
    @(posedge clk);
    ovfSvc <= 1'h1;
    @(posedge clk);
    ovfSvc <= 1'h0;
    repeat (2) @(posedge clk);
    chk("overflow serviced", 32'(ovfFlag), 32'h0);
  endtask : t_overflow

  task automatic t_ctc_wrap();
    wr(8'h08, 32'h05);
    wr(8'h04, 32'h10);
    wr(8'h0C, 32'h03);
    wr(8'h00, 32'h12);
    repeat (200) @(posedge clk);
    chk("no early match", 32'(cmpFlag), 32'h0);
    n = 0;
    while (cmpFlag !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("match after wrap", 32'(cmpFlag), 32'h1);
    chk("overflow in ctc", 32'(ovfFlag), 32'h1);
    wr(8'h00, 32'h0);
    rd(8'h04);
    chk("count under top", 32'(rv <= 32'h05), 32'h1);
    wr(8'h0C, 32'h02);
    rd(8'h0C);
    chk("flag write clear", rv, 32'h01);
    @(posedge clk);
    cmpSvc <= 1'h1;
    @(posedge clk);
    cmpSvc <= 1'h0;
  endtask : t_ctc_wrap

  task automatic wrapUp();
    if (errCount == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrapUp

  initial begin
    int divs[7] = '{1, 8, 32, 64, 128, 256, 1024};
    clk = 1'h0; rst = 1'h1; awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0;
    arvalid = 1'h0; rready = 1'h0; ovfSvc = 1'h0; cmpSvc = 1'h0;
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; errCount = 0; nChecks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_pin();
    t_period(3'h1, 8'h03, 4);
    for (int i = 0; i < 7; i++) t_period(3'(i + 1), 8'h00, divs[i]);
    t_overflow();
    t_ctc_wrap();
    wrapUp();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    errCount++;
    wrapUp();
  end
endmodule : tb_top

bind tcmp_timer8 tcmp_timer8_props tcmp_timer8_props_i (.clk(clk),
  .rst(rst), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .overflowServiced(overflowServiced),
  .compareServiced(compareServiced), .overflowFlag(overflowFlag),
  .compareFlag(compareFlag));
`default_nettype wire
